// *** dv/aix_pin_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Outside devices on the nibble port pins
// ----------------------------------------------------------------------
module aix_pin_model (
  input  wire logic [3:0] nibbleOut,
  input  wire logic [3:0] nibbleOe,
  input  wire logic [3:0] extLow,
  output logic      [3:0] nibbleIn
);
  // Pull-up on every pin; low when the port or an outside device pulls
  assign nibbleIn = ~((nibbleOe & ~nibbleOut) | extLow);
endmodule : aix_pin_model

// *** dv/aix_top_tb_top.sv ***
`timescale 1ns/1ps
module aix_top_tb_top;
  import aix_pkg::*;

  logic            clk;
  logic            rst_n;
  aix_sfr_req_type sfrReq;
  logic [7:0]      sfrRdData;
  logic [7:0]      legacyIrqEnable;
  logic [5:0]      legacyReq;
  logic [5:0]      legacyPrioHigh;
  logic            intAck;
  logic            retiStrobe;
  aix_irq_out_type irqOut;
  logic [3:0]      nibbleIn;
  logic [3:0]      nibbleOut;
  logic [3:0]      nibbleOe;
  logic [3:0]      extLow;
  int              num_errors;
  int              comparisons;
  int              cycles;

  aix_top u_aix_top (
    .clk             (clk),
    .rst_n           (rst_n),
    .sfrReq          (sfrReq),
    .sfrRdData       (sfrRdData),
    .legacyIrqEnable (legacyIrqEnable),
    .legacyReq       (legacyReq),
    .legacyPrioHigh  (legacyPrioHigh),
    .intAck          (intAck),
    .retiStrobe      (retiStrobe),
    .irqOut          (irqOut),
    .nibbleIn        (nibbleIn),
    .nibbleOut       (nibbleOut),
    .nibbleOe        (nibbleOe)
  );

  aix_pin_model u_aix_pin_model (
    .nibbleOut (nibbleOut),
    .nibbleOe  (nibbleOe),
    .extLow    (extLow),
    .nibbleIn  (nibbleIn)
  );

  always #5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  task automatic wrByte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrReq.wrEn   <= 1'b1;
    sfrReq.addr   <= a;
    sfrReq.wrData <= d;
    @(posedge clk);
    sfrReq.wrEn   <= 1'b0;
  endtask : wrByte

  task automatic wrBit(input logic [7:0] a, input logic v);
    @(posedge clk);
    sfrReq.bitWrEn <= 1'b1;
    sfrReq.bitAddr <= a;
    sfrReq.bitVal  <= v;
    @(posedge clk);
    sfrReq.bitWrEn <= 1'b0;
  endtask : wrBit

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfrReq.addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    check(sfrRdData, exp);
  endtask : rdChk

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitCyc

  task automatic pulse(input logic isAck);
    @(posedge clk);
    if (isAck)
      intAck <= 1'b1;
    else
      retiStrobe <= 1'b1;
    @(posedge clk);
    intAck     <= 1'b0;
    retiStrobe <= 1'b0;
  endtask : pulse

  task automatic irqChk(input logic r, input logic [2:0] s,
                        input logic h);
    check({7'h0, irqOut.req}, {7'h0, r});
    if (r)
    begin
      check({5'h0, irqOut.src}, {5'h0, s});
      check(irqOut.vector, 8'h03 + {2'h0, s, 3'h0});
      check({7'h0, irqOut.high}, {7'h0, h});
    end
  endtask : irqChk

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    sfrReq = '0;
    legacyIrqEnable = 8'h00;
    legacyReq = 6'h00;
    legacyPrioHigh = 6'h00;
    intAck = 1'b0;
    retiStrobe = 1'b0;
    extLow = 4'h0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    waitCyc(4);
    check({4'h0, nibbleOut}, 8'h0f);
    check({4'h0, nibbleOe}, 8'h00);
    rdChk(8'hc0, 8'h00);
    rdChk(8'hd8, 8'h0f);
    // Single-bit set and clear of each non-pending bit
    for (int i = 0; i < 8; i++)
    begin
      if (i != 1 && i != 5)
      begin
        wrBit(8'hc0 + 8'(i), 1'b1);
        rdChk(8'hc0, 8'h01 << i);
        wrBit(8'hc0 + 8'(i), 1'b0);
      end
    end
    wrBit(8'hc2, 1'b1);
    rdChk(8'hc0, 8'h04);
    wrByte(8'hc0, 8'h00);
    wrByte(8'h90, 8'h55);
    rdChk(8'h90, 8'h00);
    // Port writes drive pins, reads return pins
    wrByte(8'hd8, 8'h0a);
    waitCyc(1);
    check({nibbleOe, nibbleOut}, 8'h5a);
    rdChk(8'hd8, 8'h0a);
    wrBit(8'hd8, 1'b1);
    wrBit(8'hd9, 1'b0);
    wrBit(8'hdc, 1'b0);
    rdChk(8'hd8, 8'h09);
    wrByte(8'hd8, 8'h0f);
    // Legacy sources, vectors and gating
    legacyIrqEnable <= 8'h3f;
    for (int i = 0; i < 6; i++)
    begin
      legacyReq <= 6'h01 << i;
      waitCyc(3);
      irqChk(1'b1, 3'(i), 1'b0);
    end
    legacyIrqEnable <= 8'h1f;
    waitCyc(3);
    irqChk(1'b0, 3'h0, 1'b0);
    legacyIrqEnable <= 8'h3f;
    legacyReq <= 6'h3f;
    waitCyc(3);
    irqChk(1'b1, 3'h0, 1'b0);
    legacyPrioHigh <= 6'h20;
    waitCyc(3);
    irqChk(1'b1, 3'h5, 1'b1);
    legacyReq <= 6'h00;
    legacyPrioHigh <= 6'h00;
    // Level mode on pin 3
    wrByte(8'hc0, 8'h04);
    extLow <= 4'h8;
    waitCyc(5);
    irqChk(1'b1, 3'h6, 1'b0);
    rdChk(8'hc0, 8'h06);
    rdChk(8'hd8, 8'h07);
    wrByte(8'hc0, 8'h00);
    waitCyc(3);
    irqChk(1'b0, 3'h0, 1'b0);
    wrByte(8'hc0, 8'h44);
    extLow <= 4'hc;
    waitCyc(5);
    irqChk(1'b1, 3'h6, 1'b0);
    extLow <= 4'h0;
    waitCyc(5);
    irqChk(1'b0, 3'h0, 1'b0);
    // Edge mode on pin 2, high level, cleared by vectoring
    wrByte(8'hc0, 8'hd0);
    extLow <= 4'h4;
    waitCyc(2);
    extLow <= 4'h0;
    waitCyc(5);
    rdChk(8'hc0, 8'hf0);
    irqChk(1'b1, 3'h7, 1'b1);
    pulse(1'b1);
    waitCyc(2);
    rdChk(8'hc0, 8'hd0);
    // Preemption across levels
    legacyReq <= 6'h02;
    waitCyc(3);
    irqChk(1'b0, 3'h0, 1'b0);
    pulse(1'b0);
    waitCyc(3);
    irqChk(1'b1, 3'h1, 1'b0);
    pulse(1'b1);
    waitCyc(3);
    irqChk(1'b0, 3'h0, 1'b0);
    legacyPrioHigh <= 6'h01;
    legacyReq <= 6'h03;
    waitCyc(3);
    irqChk(1'b1, 3'h0, 1'b1);
    legacyReq <= 6'h00;
    pulse(1'b0);
    waitCyc(3);
    finish_test();
  end
endmodule : aix_top_tb_top

// *** inc/aix_pkg.sv ***
package aix_pkg;

  // ----------------------------------------------------------------------
  // Special function register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_AUX_IRQ_CTRL = 8'hc0;
  localparam logic [7:0] ADDR_NIBBLE_PORT  = 8'hd8;

  // ----------------------------------------------------------------------
  // Auxiliary interrupt control field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_C_EDGE_BIT = 0;
  localparam int unsigned CTRL_C_PEND_BIT = 1;
  localparam int unsigned CTRL_C_EN_BIT   = 2;
  localparam int unsigned CTRL_C_PRIO_BIT = 3;
  localparam int unsigned CTRL_D_EDGE_BIT = 4;
  localparam int unsigned CTRL_D_PEND_BIT = 5;
  localparam int unsigned CTRL_D_EN_BIT   = 6;
  localparam int unsigned CTRL_D_PRIO_BIT = 7;

  // ----------------------------------------------------------------------
  // Sources, vectors and port pins
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_SRC        = 8;
  localparam int unsigned NUM_LEGACY     = 6;
  localparam int unsigned SRC_W          = 3;
  localparam int unsigned PORT_W         = 4;
  localparam logic [2:0]  SRC_IRQ_C      = 3'h6;
  localparam logic [2:0]  SRC_IRQ_D      = 3'h7;
  localparam logic [7:0]  VEC_BASE       = 8'h03;
  localparam int unsigned VEC_SHIFT      = 3;
  localparam int unsigned PIN_IRQ_C      = 3;
  localparam int unsigned PIN_IRQ_D      = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] RST_PORT_LATCH = 4'hf;
  localparam logic [3:0] RST_PIN_SYNC   = 4'hf;
  localparam logic [7:0] RST_SFR_DATA   = 8'h00;

  // ----------------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       bitWrEn;
    logic [7:0] bitAddr;
    logic       bitVal;
  } aix_sfr_req_type;

  typedef struct packed {
    logic       req;
    logic       high;
    logic [2:0] src;
    logic [7:0] vector;
  } aix_irq_out_type;

  typedef struct packed {
    logic prioHigh;
    logic enable;
    logic edgeMode;
  } aix_src_cfg_type;

  typedef struct packed {
    logic prevLevel;
    logic pending;
  } aix_det_state_type;

  typedef struct packed {
    aix_src_cfg_type cfgC;
    aix_src_cfg_type cfgD;
    logic [3:0]      portLatch;
    logic [3:0]      portOe;
    logic [3:0]      pinMeta;
    logic [3:0]      pinSync;
    logic            inServLow;
    logic            inServHigh;
    aix_irq_out_type irq;
    logic [7:0]      rdData;
  } aix_top_state_type;

endpackage : aix_pkg

// *** rtl/aix_irq_detect.sv ***
`timescale 1ns/1ps
module aix_irq_detect (
  input  logic clk,
  input  logic rst_n,
  input  logic levelN,
  input  logic edgeMode,
  input  logic swWrEn,
  input  logic swVal,
  input  logic vecClear,
  output logic pending
);
  import aix_pkg::*;

  aix_det_state_type s_q;
  aix_det_state_type s_d;
  logic              fall;

  assign fall    = s_q.prevLevel & ~levelN;
  assign pending = s_q.pending;

  always_comb
  begin
    s_d           = s_q;
    s_d.prevLevel = levelN;
    if (edgeMode)
    begin
      if (swWrEn)
        s_d.pending = swVal;
      if (vecClear)
        s_d.pending = 1'b0;
      if (fall)
        s_d.pending = 1'b1;
    end
    else
    begin
      s_d.pending = ~levelN;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{prevLevel: 1'b1, pending: 1'b0};
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_edge_sets_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    edgeMode && fall |=> pending)
    else $error("falling edge did not set pending");

  a_vector_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    edgeMode && vecClear && !fall |=> !pending)
    else $error("vectoring did not clear pending");

  a_level_follows: assert property (
    @(posedge clk) disable iff (!rst_n)
    !edgeMode |=> pending == !$past(levelN))
    else $error("level mode pending does not follow input");

  a_edge_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    edgeMode && !fall && !swWrEn && !vecClear |=> $stable(pending))
    else $error("edge mode pending changed without cause");

endmodule : aix_irq_detect

// *** rtl/aix_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Control register at 0C0H; every bit settable and clearable singly, pending bits in edge mode only.
// - Bits 7..0: d prio, d enable, d pending, d edge, same for c.
// - Priority bit 1 serves the source at high level, 0 at low.
// - Added source requests only while its enable bit (2 or 6) is 1.
// - Edge-mode bit 1 detects falling edge; 0 detects active-low level.
// - Edge mode: falling edge sets pending; vectoring clears it.
// - Vectors 03H,0BH,13H,1BH,23H,2BH, irq_c 33H, irq_d 3BH.
// - Same level: fixed order from outside input a down to irq_d.
// - Six legacy sources gated by legacy enable bits 0 to 5.
// - Four-bit bit-addressable port at 0D8H; writes drive, reads pins.
// - Port pins 3 and 2 serve as I/O or added interrupt inputs.
// - Reset sets port latches, pin synchronizers and detector previous levels to ones, other registers to zero.
// - Exactly two priority levels across the eight sources.
module aix_top (
  input  logic                     clk,
  input  logic                     rst_n,
  input  aix_pkg::aix_sfr_req_type sfrReq,
  output logic [7:0]               sfrRdData,
  input  logic [7:0]               legacyIrqEnable,
  input  logic [5:0]               legacyReq,
  input  logic [5:0]               legacyPrioHigh,
  input  logic                     intAck,
  input  logic                     retiStrobe,
  output aix_pkg::aix_irq_out_type irqOut,
  input  logic [3:0]               nibbleIn,
  output logic [3:0]               nibbleOut,
  output logic [3:0]               nibbleOe
);
  import aix_pkg::*;

  aix_top_state_type s_q;
  aix_top_state_type s_d;
  logic [7:0]        ctrlWr;
  logic [7:0]        ctrlVal;
  logic [3:0]        portWr;
  logic [3:0]        portVal;
  logic [7:0]        ctrlByte;
  logic [7:0]        reqVec;
  logic [7:0]        prioVec;
  logic [7:0]        hiVec;
  logic [7:0]        loVec;
  logic [7:0]        winVec;
  logic              pendC;
  logic              pendD;
  logic              vecClearC;
  logic              vecClearD;
  logic              ackTaken;

  function automatic logic [2:0] firstSet(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        idx = i[2:0];
    end
    return idx;
  endfunction : firstSet

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sfrRdData = s_q.rdData;
  assign irqOut    = s_q.irq;
  assign nibbleOut = s_q.portLatch;
  assign nibbleOe  = s_q.portOe;

  // ----------------------------------------------------------------------
  // Added interrupt detectors
  // ----------------------------------------------------------------------
  assign ackTaken  = intAck & s_q.irq.req;
  assign vecClearC = ackTaken && (s_q.irq.src == SRC_IRQ_C);
  assign vecClearD = ackTaken && (s_q.irq.src == SRC_IRQ_D);

  aix_irq_detect u_det_c (
    .clk      (clk),
    .rst_n    (rst_n),
    .levelN   (s_q.pinSync[PIN_IRQ_C]),
    .edgeMode (s_q.cfgC.edgeMode),
    .swWrEn   (ctrlWr[CTRL_C_PEND_BIT]),
    .swVal    (ctrlVal[CTRL_C_PEND_BIT]),
    .vecClear (vecClearC),
    .pending  (pendC)
  );

  aix_irq_detect u_det_d (
    .clk      (clk),
    .rst_n    (rst_n),
    .levelN   (s_q.pinSync[PIN_IRQ_D]),
    .edgeMode (s_q.cfgD.edgeMode),
    .swWrEn   (ctrlWr[CTRL_D_PEND_BIT]),
    .swVal    (ctrlVal[CTRL_D_PEND_BIT]),
    .vecClear (vecClearD),
    .pending  (pendD)
  );

  // ----------------------------------------------------------------------
  // Register writes, port, dispatch
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d     = s_q;
    ctrlWr  = 8'h00;
    ctrlVal = 8'h00;
    portWr  = 4'h0;
    portVal = 4'h0;

    if (sfrReq.wrEn && sfrReq.addr == ADDR_AUX_IRQ_CTRL)
    begin
      ctrlWr  = 8'hff;
      ctrlVal = sfrReq.wrData;
    end
    if (sfrReq.wrEn && sfrReq.addr == ADDR_NIBBLE_PORT)
    begin
      portWr  = 4'hf;
      portVal = sfrReq.wrData[3:0];
    end
    if (sfrReq.bitWrEn && sfrReq.bitAddr[7:3] == ADDR_AUX_IRQ_CTRL[7:3])
    begin
      ctrlWr[sfrReq.bitAddr[2:0]]  = 1'b1;
      ctrlVal[sfrReq.bitAddr[2:0]] = sfrReq.bitVal;
    end
    if (sfrReq.bitWrEn && sfrReq.bitAddr[7:3] == ADDR_NIBBLE_PORT[7:3]
        && !sfrReq.bitAddr[2])
    begin
      portWr[sfrReq.bitAddr[1:0]]  = 1'b1;
      portVal[sfrReq.bitAddr[1:0]] = sfrReq.bitVal;
    end

    if (ctrlWr[CTRL_C_PRIO_BIT])
      s_d.cfgC.prioHigh = ctrlVal[CTRL_C_PRIO_BIT];
    if (ctrlWr[CTRL_C_EN_BIT])
      s_d.cfgC.enable = ctrlVal[CTRL_C_EN_BIT];
    if (ctrlWr[CTRL_C_EDGE_BIT])
      s_d.cfgC.edgeMode = ctrlVal[CTRL_C_EDGE_BIT];
    if (ctrlWr[CTRL_D_PRIO_BIT])
      s_d.cfgD.prioHigh = ctrlVal[CTRL_D_PRIO_BIT];
    if (ctrlWr[CTRL_D_EN_BIT])
      s_d.cfgD.enable = ctrlVal[CTRL_D_EN_BIT];
    if (ctrlWr[CTRL_D_EDGE_BIT])
      s_d.cfgD.edgeMode = ctrlVal[CTRL_D_EDGE_BIT];

    for (int i = 0; i < PORT_W; i++)
    begin
      if (portWr[i])
        s_d.portLatch[i] = portVal[i];
    end
    // Latch zero pulls the pin low; latch one releases it to the pull-up
    s_d.portOe  = ~s_d.portLatch;
    s_d.pinMeta = nibbleIn;
    s_d.pinSync = s_q.pinMeta;

    // Read path
    ctrlByte                  = 8'h00;
    ctrlByte[CTRL_C_EDGE_BIT] = s_q.cfgC.edgeMode;
    ctrlByte[CTRL_C_PEND_BIT] = pendC;
    ctrlByte[CTRL_C_EN_BIT]   = s_q.cfgC.enable;
    ctrlByte[CTRL_C_PRIO_BIT] = s_q.cfgC.prioHigh;
    ctrlByte[CTRL_D_EDGE_BIT] = s_q.cfgD.edgeMode;
    ctrlByte[CTRL_D_PEND_BIT] = pendD;
    ctrlByte[CTRL_D_EN_BIT]   = s_q.cfgD.enable;
    ctrlByte[CTRL_D_PRIO_BIT] = s_q.cfgD.prioHigh;
    if (sfrReq.addr == ADDR_AUX_IRQ_CTRL)
      s_d.rdData = ctrlByte;
    else if (sfrReq.addr == ADDR_NIBBLE_PORT)
      s_d.rdData = {4'h0, s_q.pinSync};
    else
      s_d.rdData = RST_SFR_DATA;

    // Request gathering and two-level selection
    reqVec = {s_q.cfgD.enable & pendD, s_q.cfgC.enable & pendC,
              legacyReq & legacyIrqEnable[5:0]};
    prioVec = {s_q.cfgD.prioHigh, s_q.cfgC.prioHigh, legacyPrioHigh};
    hiVec   = reqVec & prioVec & {8{~s_q.inServHigh}};
    loVec   = reqVec & ~prioVec
              & {8{~s_q.inServHigh & ~s_q.inServLow}};
    winVec  = (|hiVec) ? hiVec : loVec;

    // An ack drops the request for one cycle so stale state is not shown
    s_d.irq.req    = (|winVec) & ~ackTaken;
    s_d.irq.high   = |hiVec;
    s_d.irq.src    = firstSet(winVec);
    s_d.irq.vector = VEC_BASE
                     | ({5'h00, s_d.irq.src} << VEC_SHIFT);

    // In-service levels: an ack wins over a return in the same cycle
    if (ackTaken)
    begin
      if (s_q.irq.high)
        s_d.inServHigh = 1'b1;
      else
        s_d.inServLow = 1'b1;
    end
    else if (retiStrobe)
    begin
      if (s_q.inServHigh)
        s_d.inServHigh = 1'b0;
      else
        s_d.inServLow = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q           <= '0;
      s_q.portLatch <= RST_PORT_LATCH;
      s_q.pinMeta   <= RST_PIN_SYNC;
      s_q.pinSync   <= RST_PIN_SYNC;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_ctrl_bit_set: assert property (
    sfrReq.bitWrEn && sfrReq.bitVal && !sfrReq.wrEn
    && sfrReq.bitAddr == (ADDR_AUX_IRQ_CTRL + 8'h02)
    |=> s_q.cfgC.enable ##1 sfrRdData[CTRL_C_EN_BIT] || sfrReq.wrEn
        || sfrReq.bitWrEn || $past(sfrReq.addr) != ADDR_AUX_IRQ_CTRL)
    else $error("bit set of irq_c enable not applied");

  a_ctrl_layout: assert property (
    sfrReq.wrEn && !sfrReq.bitWrEn && sfrReq.addr == ADDR_AUX_IRQ_CTRL
    |=> {s_q.cfgD.prioHigh, s_q.cfgD.enable, s_q.cfgD.edgeMode,
         s_q.cfgC.prioHigh, s_q.cfgC.enable, s_q.cfgC.edgeMode}
        == {$past(sfrReq.wrData[7]), $past(sfrReq.wrData[6]),
            $past(sfrReq.wrData[4]), $past(sfrReq.wrData[3]),
            $past(sfrReq.wrData[2]), $past(sfrReq.wrData[0])})
    else $error("control byte layout mismatch");

  a_prio_map: assert property (
    irqOut.req && irqOut.src == SRC_IRQ_C
    |-> irqOut.high == $past(s_q.cfgC.prioHigh))
    else $error("irq_c served at wrong level");

  a_enable_gate: assert property (
    irqOut.req && irqOut.src >= SRC_IRQ_C
    |-> (irqOut.src == SRC_IRQ_C) ? $past(s_q.cfgC.enable)
                                  : $past(s_q.cfgD.enable))
    else $error("disabled added source requested");

  a_vector_map: assert property (
    irqOut.req |-> irqOut.vector == {2'h0, irqOut.src, 3'h3})
    else $error("vector address mismatch");

  a_poll_order: assert property (
    irqOut.req
    |-> ($past(winVec) & ((8'h01 << irqOut.src) - 8'h01)) == 8'h00)
    else $error("earlier source in polling order skipped");

  a_legacy_gate: assert property (
    irqOut.req && irqOut.src < SRC_IRQ_C
    |-> (($past(legacyIrqEnable) >> irqOut.src) & 8'h01) != 8'h00)
    else $error("disabled legacy source requested");

  a_port_write: assert property (
    sfrReq.wrEn && !sfrReq.bitWrEn && sfrReq.addr == ADDR_NIBBLE_PORT
    |=> nibbleOut == $past(sfrReq.wrData[3:0])
        && nibbleOe == ~$past(sfrReq.wrData[3:0]))
    else $error("port write not driven to pins");

  a_port_read: assert property (
    sfrReq.addr == ADDR_NIBBLE_PORT && $past(rst_n, 3)
    |=> sfrRdData == {4'h0, $past(nibbleIn, 3)})
    else $error("port read does not show pin states");

  a_irq_pin_map: assert property (
    !$past(s_q.cfgC.edgeMode) && !$past(s_q.cfgD.edgeMode)
    && $past(rst_n, 3)
    |-> pendC == !$past(nibbleIn[PIN_IRQ_C], 3)
        && pendD == !$past(nibbleIn[PIN_IRQ_D], 3))
    else $error("port pins not mapped to added interrupts");

  a_high_first: assert property (
    irqOut.req && !irqOut.high |-> $past(hiVec) == 8'h00)
    else $error("low level chosen over pending high level");

  a_no_preempt: assert property (
    irqOut.req
    |-> !$past(s_q.inServHigh) && (irqOut.high || !$past(s_q.inServLow)))
    else $error("request preempted same or higher level");

  a_ack_drops: assert property (
    intAck && irqOut.req |=> !irqOut.req)
    else $error("request not dropped after vectoring");

endmodule : aix_top
